// file: global_window_decode.sv
// Decodes a memory address against the global register window of base register zero.
// Assumes the base value comes from the configuration space outside this block.
`timescale 1ns/1ps

module global_window_decode #(
	parameter int ADDR_WIDTH = 32
) (
	// Address under test
	input wire logic [ADDR_WIDTH-1:0] memAddr,
	input wire logic [ADDR_WIDTH-1:0] baseAddressRegisterZero,
	input wire logic memSpaceEnable,
	// Result
	output logic windowHit,
	output logic [pci_cmd_pkg::WINDOW_INDEX_BITS-1:0] regIndex
);
	import pci_cmd_pkg::*;

	initial begin
		if (ADDR_WIDTH <= BAR_ZERO_SIZE_BITS) begin
			$error("global_window_decode: address too narrow");
		end
	end

	wire baseMatch;
	wire [BAR_ZERO_SIZE_BITS-1:0] offset;
	wire inWindow;
	wire aligned;

	assign baseMatch = memAddr[ADDR_WIDTH-1:BAR_ZERO_SIZE_BITS]
		== baseAddressRegisterZero[ADDR_WIDTH-1:BAR_ZERO_SIZE_BITS];
	assign offset = memAddr[BAR_ZERO_SIZE_BITS-1:0];
	// Offsets 0000..00fc, one 32-bit word each
	assign inWindow = {1'b0, offset} <= WINDOW_LAST_OFFSET;
	assign aligned = offset[WORD_OFFSET_BITS-1:0] == '0;
	assign windowHit = memSpaceEnable & baseMatch & inWindow & aligned;
	assign regIndex = offset[WORD_OFFSET_BITS +: WINDOW_INDEX_BITS];

endmodule : global_window_decode

// file: pci_cmd_pkg.sv
// Constants and carrier types for the configuration command/status block.
// Assumes a single PCI clock domain; every user of these names imports the package.
package pci_cmd_pkg;

	// Command half, bit positions
	localparam int IO_SPACE_BIT = 0;
	localparam int MEM_SPACE_BIT = 1;
	localparam int BUS_MASTER_BIT = 2;
	localparam int SPECIAL_CYCLE_BIT = 3;
	localparam int MWI_ENABLE_BIT = 4;
	localparam int VGA_SNOOP_BIT = 5;
	localparam int PARITY_RESP_BIT = 6;
	localparam int WAIT_CYCLE_BIT = 7;
	localparam int SYS_ERR_EN_BIT = 8;
	localparam int FAST_B2B_EN_BIT = 9;

	// Status half, bit positions
	localparam int CAP_66MHZ_BIT = 21;
	localparam int USER_FEATURE_BIT = 22;
	localparam int FAST_B2B_CAP_BIT = 23;
	localparam int SIG_SYS_ERR_BIT = 30;
	localparam int DET_PARITY_BIT = 31;

	// Register image: reset value and bits that are wired to one
	localparam logic [31:0] CMD_STATUS_RESET = 32'h0280_0000;
	localparam logic [31:0] CMD_STATUS_FIXED_ONES = 32'h0280_0000;

	// Global register window behind base address register zero
	localparam int BAR_ZERO_SIZE_BITS = 11;
	localparam int WINDOW_INDEX_BITS = 6;
	localparam int WORD_OFFSET_BITS = 2;
	localparam logic [11:0] WINDOW_LAST_OFFSET = 12'h0fc;
	localparam int REG_WIDTH = 32;

	// Writable command enables
	typedef struct packed {
		logic fastB2b;
		logic sysErr;
		logic parityResp;
		logic specialCycle;
		logic busMaster;
		logic memSpace;
		logic ioSpace;
	} cmd_enables_type;

	// Error and abort events reported by the bus interface, one-cycle pulses
	typedef struct packed {
		logic dataParityErr;
		logic addrParityErr;
		logic masterAbort;
		logic targetAbort;
	} bus_events_type;

endpackage : pci_cmd_pkg

// file: pci_command_status_config.sv
// Command/status configuration register with its enables, flags and gating.
// Assumes configuration and bus events arrive as pulses on the PCI clock.
`timescale 1ns/1ps

//Contract
// - Status bit 22, user-defined features, always reads zero.
// - Status bit 21, 66 MHz capability, always reads zero.
// - Bit 9 one allows fast back-to-back to different targets.
// - SERR# is driven only while the system-error enable bit 8 is one.
// - Wait-cycle control bit 7 reads zero; no stepping is done.
// - Bit 6 one takes parity actions; zero ignores detected parity errors.
// - VGA palette snoop bit 5 always reads zero.
// - Memory-write-and-invalidate enable bit 4 always reads zero.
// - Special-cycle bit 3 is writable but changes no behaviour.
// - Bus mastering happens only while bit 2 is one.
// - Memory accesses are claimed only while bit 1 is one.
// - I/O space is never claimed; bit 0 is writable without effect.
// - Global window is base register zero plus offsets 0000 to 00fc.
// - Each global register is one 32-bit word at an aligned offset.
// - Detected-parity flag is set on every parity error, whatever bit 6 says.
// - With bit 8 set, aborts, or address parity errors while bit 6 is one, set signaled-system-error.
module pci_command_status_config #(
	parameter int ADDR_WIDTH = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Configuration access to the command/status register
	input wire logic cfgSelect,
	input wire logic cfgWrite,
	input wire logic cfgRead,
	input wire logic [3:0] cfgByteEnable,
	input wire logic [31:0] cfgWriteData,
	output logic [31:0] cfgReadData,
	output logic cfgAck,
	// Bus events from the PCI interface
	input wire pci_cmd_pkg::bus_events_type busEvents,
	// Master side gating
	input wire logic masterRequest,
	input wire logic fastB2bOtherTarget,
	output logic masterRequestGated,
	output logic fastB2bAllowed,
	// Target side claiming
	input wire logic memCycle,
	input wire logic ioCycle,
	input wire logic [ADDR_WIDTH-1:0] memAddr,
	input wire logic [ADDR_WIDTH-1:0] baseAddressRegisterZero,
	output logic memClaim,
	output logic ioClaim,
	output logic [pci_cmd_pkg::WINDOW_INDEX_BITS-1:0] regIndex,
	// Error pins, open drain, active low
	output logic systemErrorOut,
	output logic systemErrorOe,
	output logic parityErrorOe,
	// Current enables
	output pci_cmd_pkg::cmd_enables_type cmdEnables
);
	import pci_cmd_pkg::*;

	initial begin
		if (ADDR_WIDTH != REG_WIDTH) begin
			$error("pci_command_status_config: PCI addresses are 32 bits");
		end
	end

	// Byte lane that carries a given bit
	function automatic logic laneOn(input logic [3:0] be, input int bitPos);
		laneOn = be[bitPos / 8];
	endfunction : laneOn

	cmd_enables_type next_cmdEnables;
	logic detectedParityFlag;
	logic signaledSysErrFlag;
	logic [31:0] statusImage;
	logic windowHit;
	logic [WINDOW_INDEX_BITS-1:0] decodedIndex;

	wire writeStrobe;
	wire readStrobe;
	wire lowLane;
	wire highLane;
	wire statusLane;
	wire anyAbort;
	wire sysErrEvent;
	wire clearParity;
	wire clearSysErr;

	assign writeStrobe = cfgSelect & cfgWrite;
	assign readStrobe = cfgSelect & cfgRead;
	assign lowLane = writeStrobe & laneOn(cfgByteEnable, IO_SPACE_BIT);
	assign highLane = writeStrobe & laneOn(cfgByteEnable, SYS_ERR_EN_BIT);
	assign statusLane = writeStrobe & laneOn(cfgByteEnable, DET_PARITY_BIT);

	// Only enables are stored; hardwired bits 7,5,4 have no storage
	always_comb begin
		next_cmdEnables = cmdEnables;
		if (lowLane) begin
			next_cmdEnables.ioSpace = cfgWriteData[IO_SPACE_BIT];
			next_cmdEnables.memSpace = cfgWriteData[MEM_SPACE_BIT];
			next_cmdEnables.busMaster = cfgWriteData[BUS_MASTER_BIT];
			next_cmdEnables.specialCycle = cfgWriteData[SPECIAL_CYCLE_BIT];
			next_cmdEnables.parityResp = cfgWriteData[PARITY_RESP_BIT];
		end
		if (highLane) begin
			next_cmdEnables.sysErr = cfgWriteData[SYS_ERR_EN_BIT];
			next_cmdEnables.fastB2b = cfgWriteData[FAST_B2B_EN_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmdEnables <= '0;
		end else begin
			cmdEnables <= next_cmdEnables;
		end
	end

	// Status flags, cleared by writing one in the upper byte
	assign clearParity = statusLane & cfgWriteData[DET_PARITY_BIT];
	assign clearSysErr = statusLane & cfgWriteData[SIG_SYS_ERR_BIT];
	assign anyAbort = busEvents.masterAbort | busEvents.targetAbort;
	assign sysErrEvent = cmdEnables.sysErr
		& (anyAbort | (busEvents.addrParityErr & cmdEnables.parityResp));

	sticky_status_flag parityFlag (
		.ref_clk(ref_clk),
		.srst(srst),
		.setPulse(busEvents.dataParityErr | busEvents.addrParityErr),
		.clearPulse(clearParity),
		.flag(detectedParityFlag)
	);

	sticky_status_flag sysErrFlag (
		.ref_clk(ref_clk),
		.srst(srst),
		.setPulse(sysErrEvent),
		.clearPulse(clearSysErr),
		.flag(signaledSysErrFlag)
	);

	// Read image: fixed ones, stored enables, flags; all else zero
	always_comb begin
		statusImage = CMD_STATUS_FIXED_ONES;
		statusImage[IO_SPACE_BIT] = cmdEnables.ioSpace;
		statusImage[MEM_SPACE_BIT] = cmdEnables.memSpace;
		statusImage[BUS_MASTER_BIT] = cmdEnables.busMaster;
		statusImage[SPECIAL_CYCLE_BIT] = cmdEnables.specialCycle;
		statusImage[MWI_ENABLE_BIT] = 1'b0;
		statusImage[VGA_SNOOP_BIT] = 1'b0;
		statusImage[PARITY_RESP_BIT] = cmdEnables.parityResp;
		statusImage[WAIT_CYCLE_BIT] = 1'b0;
		statusImage[SYS_ERR_EN_BIT] = cmdEnables.sysErr;
		statusImage[FAST_B2B_EN_BIT] = cmdEnables.fastB2b;
		statusImage[CAP_66MHZ_BIT] = 1'b0;
		statusImage[USER_FEATURE_BIT] = 1'b0;
		statusImage[SIG_SYS_ERR_BIT] = signaledSysErrFlag;
		statusImage[DET_PARITY_BIT] = detectedParityFlag;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfgReadData <= CMD_STATUS_RESET;
			cfgAck <= 1'b0;
		end else begin
			cfgAck <= readStrobe | writeStrobe;
			if (readStrobe) begin
				cfgReadData <= statusImage;
			end
		end
	end

	// SERR# and PERR# drivers; the pins only ever pull low
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			systemErrorOe <= 1'b0;
			parityErrorOe <= 1'b0;
		end else begin
			systemErrorOe <= sysErrEvent;
			parityErrorOe <= busEvents.dataParityErr & cmdEnables.parityResp;
		end
	end
	assign systemErrorOut = 1'b0;

	// Master gating; requests pass only while the host has mastering enabled
	assign masterRequestGated = masterRequest & cmdEnables.busMaster;
	assign fastB2bAllowed = ~fastB2bOtherTarget | cmdEnables.fastB2b;

	global_window_decode #(
		.ADDR_WIDTH(ADDR_WIDTH)
	) windowDecode (
		.memAddr(memAddr),
		.baseAddressRegisterZero(baseAddressRegisterZero),
		.memSpaceEnable(cmdEnables.memSpace),
		.windowHit(windowHit),
		.regIndex(decodedIndex)
	);

	assign memClaim = memCycle & windowHit;
	assign ioClaim = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			regIndex <= '0;
		end else if (memClaim) begin
			regIndex <= decodedIndex;
		end
	end

	// Checks
	a_fixed_zero_bits: assert property (@(posedge ref_clk) disable iff (srst)
		cfgAck |-> cfgReadData[USER_FEATURE_BIT] == 1'b0
			&& cfgReadData[CAP_66MHZ_BIT] == 1'b0)
		else $error("capability bits read nonzero");
	a_hardwired_cmd_zero: assert property (@(posedge ref_clk) disable iff (srst)
		$past(readStrobe) |-> !cfgReadData[WAIT_CYCLE_BIT] && !cfgReadData[VGA_SNOOP_BIT]
			&& !cfgReadData[MWI_ENABLE_BIT])
		else $error("hardwired command bits read nonzero");
	a_serr_needs_enable: assert property (@(posedge ref_clk) disable iff (srst)
		systemErrorOe |-> $past(cmdEnables.sysErr))
		else $error("SERR driven while disabled");
	a_perr_needs_resp: assert property (@(posedge ref_clk) disable iff (srst)
		busEvents.dataParityErr && !cmdEnables.parityResp |=> !parityErrorOe)
		else $error("parity error acted on while response disabled");
	a_master_gated: assert property (@(posedge ref_clk) disable iff (srst)
		masterRequestGated |-> cmdEnables.busMaster && masterRequest)
		else $error("master request passed while disabled");
	a_claim_gated: assert property (@(posedge ref_clk) disable iff (srst)
		memClaim |-> cmdEnables.memSpace && memAddr[1:0] == 2'b00)
		else $error("memory claimed while disabled");
	a_io_never: assert property (@(posedge ref_clk) disable iff (srst)
		ioCycle |-> !ioClaim)
		else $error("I/O cycle claimed");
	a_parity_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
		busEvents.dataParityErr |=> detectedParityFlag)
		else $error("detected parity flag not set");
	a_sse_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
		cmdEnables.sysErr && anyAbort |=> signaledSysErrFlag)
		else $error("signaled system error flag not set");
	a_fixed_ones_keep: assert property (@(posedge ref_clk) disable iff (srst)
		cfgAck |-> (cfgReadData & CMD_STATUS_FIXED_ONES)
			== CMD_STATUS_FIXED_ONES)
		else $error("hardwired ones changed by write");
	a_reset_clears: assert property (@(posedge ref_clk)
		srst |=> cmdEnables == '0)
		else $error("enables not cleared by reset");
	a_fast_b2b_gate: assert property (@(posedge ref_clk) disable iff (srst)
		fastB2bOtherTarget && !cmdEnables.fastB2b |-> !fastB2bAllowed)
		else $error("fast back-to-back to other target allowed");

	c_enable_write: cover property (@(posedge ref_clk) disable iff (srst)
		lowLane ##1 cmdEnables.busMaster && cmdEnables.memSpace);
	c_mem_claim: cover property (@(posedge ref_clk) disable iff (srst) memClaim);
	c_serr_pulse: cover property (@(posedge ref_clk) disable iff (srst) systemErrorOe);
	c_flag_clear: cover property (@(posedge ref_clk) disable iff (srst)
		detectedParityFlag ##1 clearParity ##1 !detectedParityFlag);

endmodule : pci_command_status_config

// file: pci_host_model.sv
// Behavioural host bridge: issues configuration cycles and bus error events.
// Assumes the device acknowledges a selected access within four clock cycles.
`timescale 1ns/1ps

module pci_host_model (
	// Clock
	input wire logic ref_clk,
	// Configuration bus
	output logic cfgSelect,
	output logic cfgWrite,
	output logic cfgRead,
	output logic [3:0] cfgByteEnable,
	output logic [31:0] cfgWriteData,
	input wire logic [31:0] cfgReadData,
	input wire logic cfgAck,
	// Bus events
	output pci_cmd_pkg::bus_events_type busEvents
);
	import pci_cmd_pkg::*;

	initial begin
		cfgSelect = 1'b0;
		cfgWrite = 1'b0;
		cfgRead = 1'b0;
		cfgByteEnable = 4'h0;
		cfgWriteData = 32'h0;
		busEvents = '0;
	end

	// Request is held until the acknowledge is sampled, then released
	task automatic cfg_access(input logic wr, input logic [3:0] be, input logic [31:0] wd,
		output logic [31:0] rd, output logic ok);
		@(negedge ref_clk);
		cfgSelect = 1'b1;
		cfgWrite = wr;
		cfgRead = !wr;
		cfgByteEnable = be;
		cfgWriteData = wd;
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge ref_clk);
			#1;
			ok = (cfgAck === 1'b1);
		end
		rd = cfgReadData;
		@(negedge ref_clk);
		cfgSelect = 1'b0;
		cfgWrite = 1'b0;
		cfgRead = 1'b0;
		// Released data lines do not keep the old value
		cfgWriteData = ~wd;
	endtask : cfg_access

	// One-cycle error event pulse
	task automatic pulse_event(input bus_events_type ev);
		@(negedge ref_clk);
		busEvents = ev;
		@(negedge ref_clk);
		busEvents = '0;
	endtask : pulse_event

endmodule : pci_host_model

// file: sticky_status_flag.sv
// One sticky status flag: set by hardware, cleared by software writing one.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/1ps

module sticky_status_flag (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Control
	input wire logic setPulse,
	input wire logic clearPulse,
	// State
	output logic flag
);
	import pci_cmd_pkg::*;

	logic next_flag;

	// A set in the same cycle as a clear wins
	assign next_flag = setPulse | (flag & ~clearPulse);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

	a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (srst)
		setPulse |=> flag)
		else $error("sticky flag lost a set");
	a_clear_drops_flag: assert property (@(posedge ref_clk) disable iff (srst)
		clearPulse && !setPulse |=> !flag)
		else $error("sticky flag ignored a clear");

endmodule : sticky_status_flag

// file: testbench.sv
// Self-checking bench for the command/status configuration block.
// Assumes the host model drives configuration cycles and bus events.
`timescale 1ns/1ps
`define CHK(act, exp) checkVal(32'(act), 32'(exp))

module testbench;
	import pci_cmd_pkg::*;

	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic masterRequest = 1'b0;
	logic fastB2bOtherTarget = 1'b0;
	logic memCycle = 1'b0;
	logic ioCycle = 1'b0;
	logic [31:0] memAddr = 32'h0;
	logic [31:0] baseAddressRegisterZero = 32'h1234_5800;
	wire logic cfgSelect, cfgWrite, cfgRead, cfgAck;
	wire logic [3:0] cfgByteEnable;
	wire logic [31:0] cfgWriteData, cfgReadData;
	wire bus_events_type busEvents;
	logic masterRequestGated, fastB2bAllowed, memClaim, ioClaim;
	logic systemErrorOut, systemErrorOe, parityErrorOe;
	logic [WINDOW_INDEX_BITS-1:0] regIndex;
	cmd_enables_type cmdEnables;
	int mismatches = 0;
	int checkCount = 0;
	int cycles = 0;

	always #10 ref_clk = ~ref_clk;

	pci_host_model pci_host_model_i (.ref_clk(ref_clk), .cfgSelect(cfgSelect),
		.cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgByteEnable(cfgByteEnable),
		.cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgAck(cfgAck),
		.busEvents(busEvents));

	pci_command_status_config pci_command_status_config_i (.ref_clk(ref_clk), .srst(srst),
		.cfgSelect(cfgSelect), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
		.cfgByteEnable(cfgByteEnable), .cfgWriteData(cfgWriteData),
		.cfgReadData(cfgReadData), .cfgAck(cfgAck), .busEvents(busEvents),
		.masterRequest(masterRequest), .fastB2bOtherTarget(fastB2bOtherTarget),
		.masterRequestGated(masterRequestGated), .fastB2bAllowed(fastB2bAllowed),
		.memCycle(memCycle), .ioCycle(ioCycle), .memAddr(memAddr),
		.baseAddressRegisterZero(baseAddressRegisterZero), .memClaim(memClaim),
		.ioClaim(ioClaim), .regIndex(regIndex), .systemErrorOut(systemErrorOut),
		.systemErrorOe(systemErrorOe), .parityErrorOe(parityErrorOe),
		.cmdEnables(cmdEnables));

	task automatic checkVal(input logic [31:0] act, input logic [31:0] exp);
		checkCount++;
		if (act !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h expected %h", $time, act, exp);
		end
	endtask : checkVal

	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : reportAndStop

	task automatic cw(input logic [3:0] be, input logic [31:0] d);
		logic [31:0] rd;
		logic ok;
		pci_host_model_i.cfg_access(1'b1, be, d, rd, ok);
		`CHK(ok, 1'b1);
	endtask : cw

	task automatic cr(input logic [31:0] exp);
		logic [31:0] rd;
		logic ok;
		pci_host_model_i.cfg_access(1'b0, 4'hf, 32'h0, rd, ok);
		`CHK(ok, 1'b1);
		`CHK(rd, exp);
	endtask : cr

	// Pulses one event and checks both error drivers in the following cycle
	task automatic ev(input logic [3:0] e, input logic serrExp, input logic perrExp);
		pci_host_model_i.pulse_event(bus_events_type'(e));
		`CHK(systemErrorOe, serrExp);
		`CHK(parityErrorOe, perrExp);
		`CHK(systemErrorOut, 1'b0);
	endtask : ev

	task automatic test_fixed();
		cr(32'h0280_0000);
		`CHK(cmdEnables, 7'h00);
		cw(4'hf, 32'hffff_ffff);
		cr(32'h0280_034f);
		cw(4'h2, 32'h0);
		cr(32'h0280_004f);
	endtask : test_fixed

	task automatic test_gating();
		cw(4'h3, 32'h0000_0001);
		@(negedge ref_clk);
		masterRequest = 1'b1;
		fastB2bOtherTarget = 1'b1;
		ioCycle = 1'b1;
		#1;
		`CHK(masterRequestGated, 1'b0);
		`CHK(fastB2bAllowed, 1'b0);
		`CHK(ioClaim, 1'b0);
		cw(4'h3, 32'h0000_0204);
		`CHK(masterRequestGated, 1'b1);
		`CHK(fastB2bAllowed, 1'b1);
		fastB2bOtherTarget = 1'b0;
		ioCycle = 1'b0;
		cw(4'h3, 32'h0);
		`CHK(fastB2bAllowed, 1'b1);
		`CHK(masterRequestGated, 1'b0);
		masterRequest = 1'b0;
	endtask : test_gating

	task automatic test_claim();
		logic [11:0] offs [5] = '{12'h0fc, 12'h000, 12'h100, 12'h0fe, 12'h800};
		logic [4:0] hits = 5'b00011;
		cw(4'h1, 32'h0000_0002);
		for (int i = 0; i < 5; i++) begin
			@(negedge ref_clk);
			memAddr = baseAddressRegisterZero + 32'(offs[i]);
			memCycle = 1'b1;
			#1;
			`CHK(memClaim, hits[i]);
			@(posedge ref_clk);
			#1;
			if (hits[i]) `CHK(regIndex, offs[i][7:2]);
		end
		cw(4'h1, 32'h0);
		memAddr = baseAddressRegisterZero;
		#1;
		`CHK(memClaim, 1'b0);
		memCycle = 1'b0;
	endtask : test_claim

	task automatic test_events();
		cw(4'h3, 32'h0000_0140);
		ev(4'h2, 1'b1, 1'b0);
		cr(32'h4280_0140);
		cw(4'h8, 32'h4000_0000);
		cr(32'h0280_0140);
		ev(4'h8, 1'b0, 1'b1);
		ev(4'h1, 1'b1, 1'b0);
		cr(32'hc280_0140);
		cw(4'hb, 32'hc000_0100);
		ev(4'h4, 1'b0, 1'b0);
		ev(4'h8, 1'b0, 1'b0);
		cr(32'h8280_0100);
		cw(4'hb, 32'hc000_0000);
		ev(4'h2, 1'b0, 1'b0);
		cr(32'h0280_0000);
	endtask : test_events

	task automatic test_midreset();
		cw(4'h3, 32'h0000_034f);
		@(negedge ref_clk);
		srst = 1'b1;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		`CHK(cmdEnables, 7'h00);
		cr(32'h0280_0000);
	endtask : test_midreset

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			reportAndStop();
		end
	end

	initial begin
		repeat (4) @(negedge ref_clk);
		srst = 1'b0;
		test_fixed();
		test_gating();
		test_claim();
		test_events();
		test_midreset();
		reportAndStop();
	end

endmodule : testbench
